// file: hw/ifct_pkg.sv
package ifct_pkg;

    // word layout
    localparam int WORD_W    = 24;
    localparam int OPC_W     = 8;
    localparam int OPC_LSB   = 16;
    localparam int LONG_W    = 40;
    localparam int SRC_LSB   = 0;
    localparam int SMOD_LSB  = 4;
    localparam int DST_LSB   = 6;
    localparam int DMOD_LSB  = 10;
    localparam int BASE_LSB  = 12;
    localparam int DPRES_BIT = 11;
    localparam int BSEL_BIT  = 11;
    localparam int BITN_LSB  = 12;
    localparam int FADR_LSB  = 0;
    localparam int FADR_W    = 13;
    localparam int DSEL_BIT  = 13;
    localparam int LIT_LSB   = 0;
    localparam int LIT_W     = 5;

    // opcode values
    localparam logic [7:0] OPC_NOP      = 8'h00;
    localparam logic [7:0] OPC_CALL_DW  = 8'h02;
    localparam logic [7:0] OPC_GOTO_DW  = 8'h04;
    localparam logic [7:0] OPC_MOVE_DW  = 8'hbe;
    localparam logic [7:0] OPC_BRANCH   = 8'h37;
    localparam logic [7:0] OPC_BRA_CMP  = 8'h01;
    localparam logic [7:0] OPC_CALL_IND = 8'h03;
    localparam logic [7:0] OPC_GOTO_IND = 8'h05;
    localparam logic [7:0] OPC_RETURN   = 8'h06;
    localparam logic [7:0] OPC_INT_RET  = 8'h07;
    localparam logic [7:0] OPC_TBL_RD   = 8'hba;
    localparam logic [7:0] OPC_TBL_WR   = 8'hbb;

    // cycle counts and reset values
    localparam logic [1:0] CYC_ZERO  = 2'h0;
    localparam logic [1:0] CYC_ONE   = 2'h1;
    localparam logic [1:0] CYC_TWO   = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    localparam logic       RST_READY = 1'b1;

    typedef enum logic [8:0] {
        CL_NOP     = 9'h001,
        CL_DOUBLE  = 9'h002,
        CL_WORK_REG_ZERO    = 9'h004,
        CL_FILE    = 9'h008,
        CL_BIT     = 9'h010,
        CL_LIT     = 9'h020,
        CL_CTRL    = 9'h040,
        CL_SKIP    = 9'h080,
        CL_CBRANCH = 9'h100
    } ifct_class_t;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_SECOND = 5'h02,
        ST_STALL  = 5'h04,
        ST_SKIP   = 5'h08,
        ST_SKIP2  = 5'h10
    } ifct_state_t;

    typedef struct packed {
        logic [3:0]        base;
        logic [3:0]        src;
        logic [1:0]        src_mode;
        logic [3:0]        dest;
        logic [1:0]        dest_mode;
        logic [FADR_W-1:0] file_addr;
        logic              dest_wreg0;
        logic [3:0]        bit_num;
        logic              bit_from_base;
        logic [LIT_W-1:0]  literal;
    } ifct_fields_t;

    localparam ifct_fields_t FLD_RST = '0;

    function automatic logic ifct_is_double(input logic [WORD_W-1:0] w);
        logic [7:0] o;
        o = w[OPC_LSB +: OPC_W];
        return (o == OPC_CALL_DW) || (o == OPC_GOTO_DW) || (o == OPC_MOVE_DW);
    endfunction

    function automatic ifct_class_t ifct_classify(input logic [7:0] o);
        ifct_class_t c;
        c = CL_WORK_REG_ZERO;
        if (o == OPC_NOP)
            c = CL_NOP;
        else if (o == OPC_CALL_DW || o == OPC_GOTO_DW || o == OPC_MOVE_DW)
            c = CL_DOUBLE;
        else if (o == OPC_BRANCH || o == OPC_BRA_CMP || o == OPC_CALL_IND
                 || o == OPC_GOTO_IND || o == OPC_RETURN || o == OPC_INT_RET
                 || o == OPC_TBL_RD || o == OPC_TBL_WR)
            c = CL_CTRL;
        else if (o[7:4] == 4'h3)
            c = CL_CBRANCH;
        else if (o[7:3] == 5'h14)
            c = CL_SKIP;
        else if (o[7:3] == 5'h15)
            c = CL_BIT;
        else if (o[7:5] == 3'h4)
            c = CL_FILE;
        else if (o[7:3] == 5'h16)
            c = CL_LIT;
        return c;
    endfunction

    // extra no-op cycles after the issue cycle
    function automatic logic [1:0] ifct_extra(input ifct_class_t c,
                                              input logic [7:0] o,
                                              input logic cond);
        logic [1:0] e;
        e = CYC_ZERO;
        if (c == CL_CTRL)
            e = (o == OPC_RETURN || o == OPC_INT_RET) ? CYC_TWO : CYC_ONE;
        else if (c == CL_CBRANCH && cond)
            e = CYC_ONE;
        return e;
    endfunction

endpackage

// file: hw/ifct_dec_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ifct_dec_if;
    import ifct_pkg::*;
    logic [WORD_W-1:0] word;
    ifct_class_t       cls;
    ifct_fields_t      fld;
    modport dec (input word, output cls, output fld);
    modport user (output word, input cls, input fld);
endinterface
`default_nettype wire

// file: hw/ifct_field_dec.sv
`timescale 1ns/1ps
`default_nettype none
module ifct_field_dec
    import ifct_pkg::*;
(
    ifct_dec_if.dec d
);
    wire [3:0] base_f   = d.word[BASE_LSB +: 4];
    wire       lit_dest = d.word[DPRES_BIT];

    assign d.cls                = ifct_classify(d.word[OPC_LSB +: OPC_W]);
    assign d.fld.base           = base_f;
    assign d.fld.src            = d.word[SRC_LSB +: 4];
    assign d.fld.src_mode       = d.word[SMOD_LSB +: 2];
    // a literal op without its own destination writes back to the base
    assign d.fld.dest           = (d.cls == CL_LIT && !lit_dest)
                                  ? base_f : d.word[DST_LSB +: 4];
    assign d.fld.dest_mode      = d.word[DMOD_LSB +: 2];
    assign d.fld.file_addr      = d.word[FADR_LSB +: FADR_W];
    assign d.fld.dest_wreg0     = !d.word[DSEL_BIT];
    assign d.fld.bit_num        = d.word[BITN_LSB +: 4];
    assign d.fld.bit_from_base  = d.word[BSEL_BIT];
    assign d.fld.literal        = d.word[LIT_LSB +: LIT_W];
endmodule
`default_nettype wire

// file: hw/ifct_core.sv
// What this block does
// - Each single-word instruction is 24 bits with an 8-bit opcode and operand fields.
// - Exactly three opcodes take two consecutive program words; all others take one.
// - A double-word instruction spans 48 bits and its second word has a zero top byte.
// - A second word fetched and run on its own executes as a no-operation.
// - Single-word ops not listed below take one cycle, or two when a test is true or the PC changes.
// - Branches, indirect call/goto, table access and returns take two or three cycles.
// - A taken skip costs two cycles over a single-word op and three over a double-word op.
// - Every double-word instruction completes in two cycles.
// - Working-register ops carry a base, a source and a destination register.
// - File-register ops carry a file address and a destination select.
// - Bit ops take the bit number from a literal or from the base register.
// - Literal arithmetic uses the base register and a literal, with an optional dest.
`timescale 1ns/1ps
`default_nettype none
module ifct_core
    import ifct_pkg::*;
(
    // clock and reset
    input  wire logic              CLOCK,
    input  wire logic              RESET_N,
    // program memory
    input  wire logic [WORD_W-1:0] PM_WORD,
    input  wire logic              PM_VALID,
    output var  logic              PM_READY,
    // condition result of the current instruction
    input  wire logic              COND_TRUE,
    // issue slot
    output var  logic              ISSUE_VALID,
    output var  logic              ISSUE_NOP,
    output var  logic              ISSUE_DOUBLE,
    output var  logic [OPC_W-1:0]  ISSUE_OPCODE,
    output var  logic [1:0]        INSTR_CYCLES,
    output var  logic [LONG_W-1:0] LONG_OPERAND,
    output var  logic              SECOND_WORD_BAD,
    // operand fields
    output var  logic [3:0]        BASE_WORK_REG,
    output var  logic [3:0]        SOURCE_WORK_REG,
    output var  logic [1:0]        SOURCE_MODE,
    output var  logic [3:0]        DEST_WORK_REG,
    output var  logic [1:0]        DEST_MODE,
    output var  logic [FADR_W-1:0] FILE_ADDR,
    output var  logic              DEST_IS_WORK_REG_ZERO,
    output var  logic [3:0]        BIT_NUM,
    output var  logic              BIT_FROM_BASE,
    output var  logic [LIT_W-1:0]  LITERAL
);

    ifct_state_t       state_r;
    ifct_state_t       state_nxt;
    logic [1:0]        cnt_r;
    logic [1:0]        cnt_nxt;
    logic              ready_r;
    logic              ready_nxt;
    logic              issue_r;
    logic              issue_nxt;
    logic              nop_r;
    logic              nop_nxt;
    logic              dbl_r;
    logic              dbl_nxt;
    logic [1:0]        cyc_r;
    logic [1:0]        cyc_nxt;
    logic              bad_r;
    logic              bad_nxt;
    logic [WORD_W-1:0] hold_r;
    logic [WORD_W-1:0] hold_nxt;
    logic [OPC_W-1:0]  opc_r;
    logic [OPC_W-1:0]  opc_nxt;
    logic [LONG_W-1:0] long_r;
    logic [LONG_W-1:0] long_nxt;
    ifct_fields_t      fld_r;
    ifct_fields_t      fld_nxt;
    logic              load_one;
    logic              load_two;

    ifct_dec_if dec_bus ();

    ifct_field_dec u_dec (
        .d (dec_bus)
    );

    assign dec_bus.word = PM_WORD;

    // decode and selection
    wire             take      = PM_VALID && ready_r;
    wire             word_dbl  = ifct_is_double(PM_WORD);
    wire [1:0]       extra     = ifct_extra(dec_bus.cls, PM_WORD[OPC_LSB +: OPC_W],
                                            COND_TRUE);
    wire             skip_go   = (dec_bus.cls == CL_SKIP) && COND_TRUE;
    wire [1:0]       cyc_first = skip_go ? CYC_TWO : 2'(extra + CYC_ONE);
    wire             top_nz    = |PM_WORD[OPC_LSB +: OPC_W];

    // merged operand: low 16 bits of the first word, then the whole second word
    assign opc_nxt  = load_two ? hold_r[OPC_LSB +: OPC_W]
                    : load_one ? PM_WORD[OPC_LSB +: OPC_W] : opc_r;
    assign long_nxt = load_two ? {hold_r[OPC_LSB-1:0], PM_WORD}
                    : load_one ? {{(LONG_W-WORD_W){1'b0}}, PM_WORD} : long_r;
    assign fld_nxt  = load_one ? dec_bus.fld : load_two ? FLD_RST : fld_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        ready_nxt = ready_r;
        issue_nxt = 1'b0;
        nop_nxt   = 1'b0;
        dbl_nxt   = dbl_r;
        cyc_nxt   = cyc_r;
        bad_nxt   = bad_r;
        hold_nxt  = hold_r;
        load_one  = 1'b0;
        load_two  = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (take && word_dbl) begin
                    // wait in ST_SECOND until the second half is taken
                    hold_nxt  = PM_WORD;
                    state_nxt = ST_SECOND;
                end else if (take) begin
                    load_one  = 1'b1;
                    issue_nxt = 1'b1;
                    nop_nxt   = (dec_bus.cls == CL_NOP);
                    dbl_nxt   = 1'b0;
                    bad_nxt   = 1'b0;
                    cyc_nxt   = cyc_first;
                    if (extra != CYC_ZERO) begin
                        cnt_nxt   = extra;
                        ready_nxt = 1'b0;
                        state_nxt = ST_STALL;
                    end else if (skip_go) begin
                        state_nxt = ST_SKIP;
                    end
                end
            end
            ST_SECOND: begin
                if (take) begin
                    load_two  = 1'b1;
                    issue_nxt = 1'b1;
                    dbl_nxt   = 1'b1;
                    cyc_nxt   = CYC_TWO;
                    bad_nxt   = top_nz;
                    state_nxt = ST_IDLE;
                end
            end
            ST_STALL: begin
                // extra cycles issue as no-ops and hold off the fetch
                nop_nxt = 1'b1;
                cnt_nxt = 2'(cnt_r - CYC_ONE);
                if (cnt_r == CYC_ONE) begin
                    ready_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            ST_SKIP: begin
                if (take) begin
                    nop_nxt   = 1'b1;
                    state_nxt = word_dbl ? ST_SKIP2 : ST_IDLE;
                    cyc_nxt   = word_dbl ? CYC_THREE : cyc_r;
                end
            end
            ST_SKIP2: begin
                if (take) begin
                    // the skipped second word is discarded as a no-op
                    nop_nxt   = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                ready_nxt = RST_READY;
                cnt_nxt   = CYC_ZERO;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            state_r <= ST_IDLE;
            cnt_r   <= CYC_ZERO;
            ready_r <= RST_READY;
            issue_r <= 1'b0;
            nop_r   <= 1'b0;
            dbl_r   <= 1'b0;
            cyc_r   <= CYC_ZERO;
            bad_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            ready_r <= ready_nxt;
            issue_r <= issue_nxt;
            nop_r   <= nop_nxt;
            dbl_r   <= dbl_nxt;
            cyc_r   <= cyc_nxt;
            bad_r   <= bad_nxt;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            hold_r <= '0;
            opc_r  <= OPC_NOP;
            long_r <= '0;
            fld_r  <= FLD_RST;
        end else begin
            hold_r <= hold_nxt;
            opc_r  <= opc_nxt;
            long_r <= long_nxt;
            fld_r  <= fld_nxt;
        end
    end

    assign PM_READY              = ready_r;
    assign ISSUE_VALID           = issue_r;
    assign ISSUE_NOP             = nop_r;
    assign ISSUE_DOUBLE          = dbl_r;
    assign ISSUE_OPCODE          = opc_r;
    assign INSTR_CYCLES          = cyc_r;
    assign LONG_OPERAND          = long_r;
    assign SECOND_WORD_BAD       = bad_r;
    assign BASE_WORK_REG         = fld_r.base;
    assign SOURCE_WORK_REG       = fld_r.src;
    assign SOURCE_MODE           = fld_r.src_mode;
    assign DEST_WORK_REG         = fld_r.dest;
    assign DEST_MODE             = fld_r.dest_mode;
    assign FILE_ADDR             = fld_r.file_addr;
    assign DEST_IS_WORK_REG_ZERO = fld_r.dest_wreg0;
    assign BIT_NUM               = fld_r.bit_num;
    assign BIT_FROM_BASE         = fld_r.bit_from_base;
    assign LITERAL               = fld_r.literal;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);

    wire idle_take = take && (state_r == ST_IDLE);
    wire [OPC_W-1:0] pm_opc = PM_WORD[OPC_LSB +: OPC_W];

    property p_opcode_field;
        idle_take && !word_dbl
        |=> ISSUE_OPCODE == $past(pm_opc) && LONG_OPERAND[WORD_W-1:0] == $past(PM_WORD);
    endproperty
    a_opcode_field: assert property (p_opcode_field) else $error("opcode field lost");

    property p_double_waits;
        idle_take && word_dbl |=> !ISSUE_VALID && state_r == ST_SECOND && PM_READY;
    endproperty
    a_double_waits: assert property (p_double_waits) else $error("double not held");

    property p_second_top;
        take && state_r == ST_SECOND && top_nz |=> ISSUE_DOUBLE && SECOND_WORD_BAD;
    endproperty
    a_second_top: assert property (p_second_top) else $error("bad second word missed");

    property p_lone_second;
        idle_take && PM_WORD[OPC_LSB +: OPC_W] == OPC_NOP |=> ISSUE_VALID && ISSUE_NOP;
    endproperty
    a_lone_second: assert property (p_lone_second) else $error("lone second not nop");

    property p_plain_one;
        idle_take && dec_bus.cls == CL_WORK_REG_ZERO
        |=> ISSUE_VALID && INSTR_CYCLES == CYC_ONE && PM_READY;
    endproperty
    a_plain_one: assert property (p_plain_one) else $error("plain op not one cycle");

    property p_return_three;
        idle_take && PM_WORD[OPC_LSB +: OPC_W] == OPC_RETURN
        |=> ISSUE_VALID && INSTR_CYCLES == CYC_THREE ##1 (ISSUE_NOP && !PM_READY)
            ##1 (ISSUE_NOP && PM_READY);
    endproperty
    a_return_three: assert property (p_return_three) else $error("return timing");

    property p_skip_double;
        take && state_r == ST_SKIP && word_dbl
        |=> ISSUE_NOP && INSTR_CYCLES == CYC_THREE && state_r == ST_SKIP2;
    endproperty
    a_skip_double: assert property (p_skip_double) else $error("skip over double");

    property p_double_two;
        take && state_r == ST_SECOND |=> ISSUE_VALID && ISSUE_DOUBLE && INSTR_CYCLES == CYC_TWO;
    endproperty
    a_double_two: assert property (p_double_two) else $error("double not two cycles");

    property p_work_reg_zero_fields;
        idle_take && dec_bus.cls == CL_WORK_REG_ZERO
        |=> BASE_WORK_REG == LONG_OPERAND[BASE_LSB +: 4]
            && SOURCE_WORK_REG == LONG_OPERAND[SRC_LSB +: 4];
    endproperty
    a_work_reg_zero_fields: assert property (p_work_reg_zero_fields) else $error("work_reg_zero fields");

    property p_file_dest;
        idle_take && dec_bus.cls == CL_FILE
        |=> DEST_IS_WORK_REG_ZERO == !LONG_OPERAND[DSEL_BIT];
    endproperty
    a_file_dest: assert property (p_file_dest) else $error("file dest select");

    property p_bit_select;
        idle_take && dec_bus.cls == CL_BIT |=> BIT_FROM_BASE == LONG_OPERAND[BSEL_BIT];
    endproperty
    a_bit_select: assert property (p_bit_select) else $error("bit select");

    property p_lit_dest;
        idle_take && dec_bus.cls == CL_LIT && !PM_WORD[DPRES_BIT]
        |=> DEST_WORK_REG == BASE_WORK_REG;
    endproperty
    a_lit_dest: assert property (p_lit_dest) else $error("literal dest");

    property p_merge;
        take && state_r == ST_SECOND
        |=> LONG_OPERAND == {hold_r[OPC_LSB-1:0], $past(PM_WORD)};
    endproperty
    a_merge: assert property (p_merge) else $error("merge wrong");

    c_double: cover property (take && state_r == ST_SECOND ##1 ISSUE_DOUBLE);
    c_skip_dbl: cover property (state_r == ST_SKIP2 ##1 state_r == ST_IDLE);
    c_return: cover property (ISSUE_VALID && INSTR_CYCLES == CYC_THREE);
    c_cbranch: cover property (idle_take && dec_bus.cls == CL_CBRANCH && COND_TRUE);

endmodule
`default_nettype wire

// file: testbench/ifct_pmem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ifct_pmem_model
    import ifct_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              reset_n,
    // loading from the bench
    input  wire logic              push,
    input  wire logic [WORD_W-1:0] push_word,
    input  wire logic              push_cond,
    input  wire logic              stall,
    // program memory side
    output var  logic [WORD_W-1:0] pm_word,
    output var  logic              pm_valid,
    input  wire logic              pm_ready,
    output var  logic              cond_true
);
    logic [WORD_W:0] q[$];
    logic [WORD_W:0] head;

    initial begin
        pm_word   = '0;
        pm_valid  = 1'b0;
        cond_true = 1'b0;
    end

    // an offered word is held until taken; stall only delays words not yet offered
    always @(posedge clock) begin
        if (!reset_n) begin
            q.delete();
        end else begin
            if (pm_valid && pm_ready)
                void'(q.pop_front());
            if (push)
                q.push_back({push_cond, push_word});
        end
        if (reset_n && q.size() > 0 && (!stall || (pm_valid && !pm_ready))) begin
            head = q[0];
            pm_valid  <= 1'b1;
            pm_word   <= head[WORD_W-1:0];
            cond_true <= head[WORD_W];
        end else begin
            // idle lines toggle so a stale word can never pass for a fresh one
            pm_valid  <= 1'b0;
            pm_word   <= ~pm_word;
            cond_true <= ~cond_true;
        end
    end
endmodule
`default_nettype wire

// file: testbench/test_instruction_format_and_cycle_timing.sv
`timescale 1ns/1ps
`default_nettype none
module test_instruction_format_and_cycle_timing;
    import ifct_pkg::*;
    logic              clock, reset_n, push, push_cond, stall;
    logic [WORD_W-1:0] push_word, pm_word;
    logic              pm_valid, pm_ready, cond_true, iv, inop, idbl, bad, wz, bfb;
    logic [OPC_W-1:0]  iop;
    logic [1:0]        cyc, smod, dmod;
    logic [LONG_W-1:0] lop;
    logic [3:0]        bre, sre, dre, bnum;
    logic [FADR_W-1:0] fad;
    logic [LIT_W-1:0]  lit;
    logic [7:0]        op;
    logic [1:0]        ex;
    int                n_errors, num_checks, cycles, nv, nn, nrl;

    ifct_pmem_model pm (.clock(clock), .reset_n(reset_n), .push(push), .push_word(push_word),
        .push_cond(push_cond), .stall(stall), .pm_word(pm_word), .pm_valid(pm_valid),
        .pm_ready(pm_ready), .cond_true(cond_true));

    ifct_core DUT (.CLOCK(clock), .RESET_N(reset_n), .PM_WORD(pm_word), .PM_VALID(pm_valid),
        .PM_READY(pm_ready), .COND_TRUE(cond_true), .ISSUE_VALID(iv), .ISSUE_NOP(inop),
        .ISSUE_DOUBLE(idbl), .ISSUE_OPCODE(iop), .INSTR_CYCLES(cyc), .LONG_OPERAND(lop),
        .SECOND_WORD_BAD(bad), .BASE_WORK_REG(bre), .SOURCE_WORK_REG(sre), .SOURCE_MODE(smod),
        .DEST_WORK_REG(dre), .DEST_MODE(dmod), .FILE_ADDR(fad), .DEST_IS_WORK_REG_ZERO(wz),
        .BIT_NUM(bnum), .BIT_FROM_BASE(bfb), .LITERAL(lit));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input logic [LONG_W-1:0] seen, input logic [LONG_W-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic tally;
        if (iv === 1'b1) nv++;
        if (inop === 1'b1) nn++;
        if (pm_ready === 1'b0) nrl++;
    endtask

    // the first put of a group clears the tallies; issues launched while
    // later words are still being queued must be counted as well
    task automatic put(input logic [WORD_W-1:0] w, input logic c);
        @(negedge clock);
        if (push !== 1'b1) begin
            nv = 0;
            nn = 0;
            nrl = 0;
        end
        tally();
        push = 1'b1;
        push_word = w;
        push_cond = c;
    endtask

    // counts issues, no-op slots and refused cycles over a window
    task automatic watch(input int n);
        repeat (n) begin
            @(negedge clock);
            push = 1'b0;
            tally();
        end
    endtask

    task automatic t_work_reg_zero;
        put(24'hc05a53, 1'b0);
        put(24'hc15a53, 1'b0);
        watch(6);
        check(nv, 2);
        check({iop, cyc, idbl}, {8'hc1, CYC_ONE, 1'b0});
        check({bre, sre, smod, dre, dmod}, {4'h5, 4'h3, 2'h1, 4'h9, 2'h2});
        check(lop, {16'h0, 24'hc15a53});
        $display("work_reg_zero test done");
    endtask

    task automatic t_file_bit_lit;
        put(24'h802abc, 1'b0);
        watch(4);
        check({fad, wz}, {13'h0abc, 1'b0});
        put(24'h800123, 1'b0);
        watch(4);
        check({fad, wz}, {13'h0123, 1'b1});
        put(24'ha87800, 1'b0);
        watch(4);
        check({bnum, bfb}, {4'h7, 1'b1});
        put(24'ha83000, 1'b0);
        watch(4);
        check({bnum, bfb}, {4'h3, 1'b0});
        put(24'hb04895, 1'b0);
        watch(4);
        check({bre, lit, cyc}, {4'h4, 5'h15, CYC_ONE});
        put(24'hb04095, 1'b0);
        watch(4);
        check({dre, bre, lit}, {4'h4, 4'h4, 5'h15});
        $display("file bit literal test done");
    endtask

    task automatic t_double;
        for (int i = 0; i < 3; i++) begin
            op = (i == 0) ? OPC_CALL_DW : (i == 1) ? OPC_GOTO_DW : OPC_MOVE_DW;
            put({op, 16'h1357}, 1'b0);
            put(24'h00abcd, 1'b0);
            watch(6);
            check(nv, 1);
            check({idbl, cyc, iop}, {1'b1, CYC_TWO, op});
            check(lop, {16'h1357, 24'h00abcd});
            check({bad, bre, sre}, 9'h0);
        end
        // slow memory between the two words of a double
        put(24'h041234, 1'b0);
        put(24'h5a0001, 1'b0);
        stall = 1'b1;
        @(negedge clock);
        push = 1'b0;
        repeat (3) @(negedge clock);
        stall = 1'b0;
        watch(6);
        check(nv, 1);
        check(bad, 1'b1);
        check(lop, {16'h1234, 24'h5a0001});
        put(24'h001234, 1'b0);
        watch(4);
        check(nn, 1);
        $display("double test done");
    endtask

    task automatic t_ctrl;
        for (int i = 0; i < 10; i++) begin
            op = (i < 8) ? 8'h01 + 8'(i) : 8'h35;
            if (i == 7) op = OPC_BRANCH;
            if (i == 1) op = OPC_CALL_IND;
            if (i == 2) op = OPC_TBL_RD;
            if (i == 3) op = OPC_TBL_WR;
            ex = (op == OPC_RETURN || op == OPC_INT_RET) ? CYC_THREE
                 : (i == 9) ? CYC_ONE : CYC_TWO;
            put({op, 16'h0000}, i == 8);
            watch(6);
            check({nv, cyc}, {32'd1, ex});
            check({nn[7:0], nrl[7:0]}, {8'(ex) - 8'h01, 8'(ex) - 8'h01});
        end
        $display("control timing test done");
    endtask

    task automatic t_skip;
        put(24'ha30000, 1'b1);
        put(24'hc05a53, 1'b0);
        watch(6);
        check({nv[7:0], nn[7:0], cyc}, {8'h01, 8'h01, CYC_TWO});
        put(24'ha30000, 1'b1);
        put(24'h021357, 1'b0);
        put(24'h00abcd, 1'b0);
        watch(8);
        check({nv[7:0], nn[7:0], cyc}, {8'h01, 8'h02, CYC_THREE});
        put(24'ha30000, 1'b0);
        put(24'hc05a53, 1'b0);
        watch(6);
        check({nv[7:0], iop, cyc}, {8'h02, 8'hc0, CYC_ONE});
        $display("skip test done");
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        reset_n = 1'b0;
        push = 1'b0;
        push_cond = 1'b0;
        stall = 1'b0;
        push_word = '0;
        repeat (8) @(negedge clock);
        reset_n = 1'b1;
        check(lop, 40'h0);
        check({pm_ready, iv, inop, cyc}, {RST_READY, 1'b0, 1'b0, CYC_ZERO});
        t_work_reg_zero();
        t_file_bit_lit();
        t_double();
        t_ctrl();
        t_skip();
        close_out();
    end
endmodule
`default_nettype wire
